// [bench/rfs_env_model.sv]
// far-side model: dc source, load and trigger switches
`timescale 1ns/1ps
module rfs_env_model (
  // scenario controls
  input  wire logic [9:0]  src_volt_i,
  input  wire logic [15:0] load_cur_i,
  input  wire logic        main_on_i,
  input  wire logic        ovr_hold_i,
  input  wire logic        closed_i,
  // lines toward the relay
  output logic [9:0]       volt_o,
  output logic [15:0]      current_o,
  output logic             main_trig_o,
  output logic             ovr_trig_o
);
  // load draws current only through a closed array
  assign volt_o      = src_volt_i;
  assign current_o   = closed_i ? load_cur_i : 16'h0000;
  assign main_trig_o = main_on_i;
  assign ovr_trig_o  = ovr_hold_i; // momentary push, released by the operator
endmodule

// [bench/tb_top.sv]
// self-checking bench for the relay fault supervisor
`timescale 1ns/1ps
module tb_top;
  import rfs_pkg::*;
  localparam int TC = 4;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mtr;
  logic        otr;
  logic [15:0] cur;
  logic [9:0]  volt;
  logic        oc = 1'b0;
  logic        ocl = 1'b0;
  logic        ot = 1'b0;
  logic        sw;
  logic        led;
  logic        lp;
  logic [9:0]  sv = 10'd150;
  logic [15:0] ld = 16'h0000;
  logic        mon = 1'b0;
  logic        ovh = 1'b0;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  a;
  int          failures = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          on;
  // clock generation
  always #12.5 clk = ~clk;
  rfs_top #(.TICK_CYC(TC), .BIDIR(1'b1)) DUT (
    .ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .main_trig_i(mtr), .ovr_trig_i(otr),
    .current_i(cur), .volt_i(volt), .oc_fault_i(oc), .oc_led_i(ocl),
    .ot_fault_i(ot), .switch_close_o(sw), .fault_led_o(led), .low_power_o(lp));
  rfs_env_model ENV (
    .src_volt_i(sv), .load_cur_i(ld), .main_on_i(mon), .ovr_hold_i(ovh),
    .closed_i(sw), .volt_o(volt), .current_o(cur), .main_trig_o(mtr),
    .ovr_trig_o(otr));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) failures++;
  endtask
  // count led-on samples over n cycles
  task automatic leds(input int n);
    on = 0;
    repeat (n) begin
      @(negedge clk);
      if (led === 1'b1) on++;
    end
    @(posedge clk);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      failures++;
      finish_test;
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, A_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0100);
    apb(1'b1, A_CTRL, 32'h0000_032E);
    apb(1'b0, A_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_032E);
    apb(1'b1, A_CTRL, CFG_RST);
    apb(1'b1, A_STAT, 32'hFFFF_FFFF);
    check({31'h0, er}, 32'h0);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    check({er, rd[30:0]}, 32'h8000_0000);
    mon <= 1'b1;
    repeat (10) @(posedge clk);
    check({31'h0, sw}, 32'h1);
    // every under- and over-voltage pair in turn, one step past threshold
    for (int i = 0; i < 8; i++) begin
      a = A_UV0 + 8'(4 * i);
      apb(1'b1, a, {1'b1, 21'd2, (i < 4) ? 10'd120 : 10'd180});
      sv <= (i < 4) ? 10'd119 : 10'd181;
      repeat (8) @(posedge clk);
      check({31'h0, sw}, 32'h1);
      repeat (40) @(posedge clk);
      check({31'h0, sw}, 32'h0);
      leds(40);
      check(32'(on), 32'd40);
      if (i == 0) begin
        ot <= 1'b1;
        leds(1200);
        check(32'(on > 0 && on < 1200), 32'h1);
        ot <= 1'b0;
        repeat (4) @(posedge clk);
        leds(50);
        check(32'(on), 32'd50);
        ovh <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, sw}, 32'h1);
        ovh <= 1'b0;
      end
      sv <= 10'd150;
      apb(1'b1, a, 32'h0000_0000);
      repeat (10) @(posedge clk);
      check({31'h0, sw}, 32'h1);
    end
    // circuit break level one, toggle policy
    ld <= 16'd200;
    apb(1'b1, A_CB0, 32'h8001_0064);
    repeat (100) @(posedge clk);
    check({31'h0, sw}, 32'h0);
    apb(1'b0, A_STAT, 32'h0000_0000);
    check({29'h0, rd[11], rd[4:3]}, 32'h5);
    ld <= 16'h0000;
    leds(5000);
    check(32'(on > 0 && on < 5000), 32'h1);
    mon <= 1'b0;
    repeat (10) @(posedge clk);
    mon <= 1'b1;
    repeat (20) @(posedge clk);
    check({31'h0, sw}, 32'h0);
    repeat (LOCK_TK * TC) @(posedge clk);
    check({31'h0, sw}, 32'h0);
    // limited retry with its count used up falls back to toggle
    apb(1'b1, A_CTRL, 32'h0000_0010);
    repeat (10) @(posedge clk);
    check({31'h0, sw}, 32'h0);
    mon <= 1'b0;
    repeat (10) @(posedge clk);
    mon <= 1'b1;
    repeat (10) @(posedge clk);
    check({31'h0, sw}, 32'h1);
    apb(1'b1, A_CB0, 32'h0000_0000);
    // level two on reverse current, unlimited retry after lockout
    apb(1'b1, A_CTRL, 32'h0000_0020);
    apb(1'b1, A_CB0 + 8'h04, 32'hC001_0064);
    ld <= 16'd200;
    repeat (40) @(posedge clk);
    check({31'h0, sw}, 32'h1);
    ld <= 16'hFF38;
    repeat (40) @(posedge clk);
    apb(1'b0, A_STAT, 32'h0000_0000);
    check({29'h0, sw, rd[4:3]}, 32'h2);
    ld <= 16'h0000;
    leds(3000);
    check(32'(on > 0 && on < 3000), 32'h1);
    repeat (LOCK_TK * TC) @(posedge clk);
    check({31'h0, sw}, 32'h1);
    apb(1'b1, A_CB0 + 8'h04, 32'h0000_0000);
    apb(1'b1, A_CTRL, 32'h0000_0000);
    // sleep: idle countdown, restart on disturbance, expiry, wake enables
    apb(1'b1, A_SLPI, 32'h0000_0064);
    apb(1'b1, A_SLPT, 32'h0000_0014);
    apb(1'b1, A_CTRL, 32'h0000_0001);
    repeat (40) @(posedge clk);
    ld <= 16'd200;
    repeat (60) @(posedge clk);
    ld <= 16'h0000;
    repeat (60) @(posedge clk);
    check({31'h0, lp}, 32'h0);
    repeat (200) @(posedge clk);
    check({29'h0, lp, sw, led}, 32'h4);
    mon <= 1'b0;
    repeat (20) @(posedge clk);
    check({31'h0, lp}, 32'h1);
    apb(1'b1, A_CTRL, 32'h0000_0005);
    mon <= 1'b1;
    repeat (20) @(posedge clk);
    check({31'h0, lp}, 32'h0);
    apb(1'b1, A_CTRL, 32'h0000_0000);
    // external current fault outranks over-temperature
    ot <= 1'b1;
    oc <= 1'b1;
    repeat (4) @(posedge clk);
    leds(600);
    check(32'(on), 32'd0);
    ocl <= 1'b1;
    repeat (4) @(posedge clk);
    leds(20);
    check(32'(on), 32'd20);
    finish_test;
  end
endmodule

// [rtl/rfs_pkg.sv]
// constants and types shared by the relay fault supervisor
package rfs_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ       = 40_000_000;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYC_DEF = CLK_HZ / 1_000_000 * TICK_US;
  localparam int LOCK_S       = 10;
  localparam int LOCK_TK      = LOCK_S * 1_000_000 / TICK_US;
  localparam int WD_S         = 33;
  localparam int WD_TK        = WD_S * 1_000_000 / TICK_US;
  localparam int PROBE_MS     = 66;
  localparam int PROBE_TK     = PROBE_MS * 1000 / TICK_US;
  localparam int VSTEP_MS     = 2;
  localparam int VSTEP_TK     = VSTEP_MS * 1000 / TICK_US;
  localparam int CB1_HALF_MS  = 1000;
  localparam int CB2_HALF_MS  = 500;
  localparam int OT_HALF_MS   = 125;
  localparam int CB1_HALF_TK  = CB1_HALF_MS * 1000 / TICK_US;
  localparam int CB2_HALF_TK  = CB2_HALF_MS * 1000 / TICK_US;
  localparam int OT_HALF_TK   = OT_HALF_MS * 1000 / TICK_US;
  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam int         NREG   = 13;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CB0  = 8'h04;
  localparam logic [7:0] A_UV0  = 8'h0C;
  localparam logic [7:0] A_OV0  = 8'h1C;
  localparam logic [7:0] A_SLPT = 8'h2C;
  localparam logic [7:0] A_SLPI = 8'h30;
  localparam logic [7:0] A_STAT = 8'h34;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int F_SLEEP  = 0;
  localparam int F_WK_WDT = 1;
  localparam int F_WK_MN  = 2;
  localparam int F_WK_OV  = 3;
  localparam int F_POL    = 4;
  localparam int F_TRY    = 8;
  localparam int F_VTH    = 0;
  localparam int VTH_W    = 10;
  localparam int F_VDL    = 10;
  localparam int VDL_W    = 21;
  localparam int F_CLV    = 0;
  localparam int F_CDL    = 16;
  localparam int CDL_W    = 14;
  localparam int F_DIR    = 30;
  localparam int F_EN     = 31;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0] POL_TOGGLE = 2'h0;
  localparam logic [1:0] POL_LIMIT  = 2'h1;
  localparam logic [1:0] POL_UNLIM  = 2'h2;
  localparam logic [2:0] LED_NONE = 3'h0;
  localparam logic [2:0] LED_VOLT = 3'h1;
  localparam logic [2:0] LED_OT   = 3'h2;
  localparam logic [2:0] LED_CB1  = 3'h3;
  localparam logic [2:0] LED_CB2  = 3'h4;
  localparam logic [2:0] LED_OC   = 3'h5;
  typedef enum logic [2:0] {
    ST_AWAKE  = 3'b001,
    ST_LOWPWR = 3'b010,
    ST_PROBE  = 3'b100
  } rfs_slp_t;
endpackage

// [rtl/rfs_qual_if.sv]
// signals between the supervisor and one qualification timer
`timescale 1ns/1ps
interface rfs_qual_if #(parameter int DW = 22);
  logic          tick;
  logic          cond;
  logic [DW-1:0] dly;
  logic          fired;
  logic          running;
  modport tmr (input tick, cond, dly, output fired, running);
  modport ctl (output tick, cond, dly, input fired, running);
endinterface

// [rtl/rfs_qual_tmr.sv]
// qualification timer: condition must hold for a delay in ticks
`timescale 1ns/1ps
module rfs_qual_tmr
  import rfs_pkg::*;
#(
  parameter int DW = 22
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // timer link
  rfs_qual_if.tmr  qi
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic          fired;
  } rfs_qt_t;

  rfs_qt_t s_reg;
  rfs_qt_t s_next;

  if (DW < 2) begin : g_bad_dw
    $error("rfs_qual_tmr: DW too small");
  end

  // count while the condition holds, drop at once when it goes
  always_comb begin
    s_next = s_reg;
    if (!qi.cond) begin
      s_next = '0;
    end else if (!s_reg.fired && qi.tick) begin
      if (s_reg.cnt + DW'(1) >= qi.dly) begin
        s_next.fired = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + DW'(1);
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign qi.fired   = s_reg.fired;
  assign qi.running = qi.cond && !s_reg.fired;

  a_qual_drop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !qi.cond |=> !qi.fired)
    else $error("qualified fault survived loss of its condition");
endmodule

// [rtl/rfs_top.sv]
// relay fault supervisor: circuit break, voltage faults, sleep, fault led
// Contract
// - two circuit-break levels; bi-directional variant picks direction per level
// - circuit-break trip opens array and blinks that level's pattern
// - reset policy: trigger toggle, limited auto-retry, or unlimited retry
// - every policy waits a ten second lockout before closing again
// - voltage beyond threshold for the whole delay opens the array
// - thresholds in 0.1 V steps, delays in 2 ms steps, long range
// - four under- and four over-voltage pairs, each with its own timer
// - voltage fault opens array; steady led only without higher faults
// - during voltage fault, override plus main trigger closes the array
// - with sleep enabled, idle starts the sleep timer
// - leaving idle clears the sleep timer until idle again
// - sleep expiry opens array, darkens indicators, enters low power
// - watchdog wake about every 33 s restores monitoring
// - after watchdog wake, stay awake on change, else sleep after 66 ms
// - main or override trigger change wakes from sleep
// - watchdog, main and override wake sources have separate enables
// - led shows highest active fault, falls to next when it clears
// - priorities: current faults 3, over-temperature 2, voltage 1
// - after a current trip, main toggle resets only after lockout
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module rfs_top
  import rfs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF,
  parameter bit BIDIR    = 1'b1
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // trigger pins
  input  wire logic        main_trig_i,
  input  wire logic        ovr_trig_i,
  // measurements and external faults
  input  wire logic [15:0] current_i,
  input  wire logic [9:0]  volt_i,
  input  wire logic        oc_fault_i,
  input  wire logic        oc_led_i,
  input  wire logic        ot_fault_i,
  // relay outputs
  output logic             switch_close_o,
  output logic             fault_led_o,
  output logic             low_power_o
);
  localparam int NQ = 10;
  localparam int DW = 22;
  typedef struct packed {
    logic [31:0]            tdiv;
    logic [NREG-1:0][31:0]  cfg;
    logic                   m1, o1, m2, o2, mp, op;
    logic                   closed;
    logic [1:0]             cb;
    logic [13:0]            lock;
    logic [3:0]             tries;
    logic [31:0]            slp;
    rfs_slp_t               st;
    logic [15:0]            wd;
    logic [6:0]             pr;
    logic                   uvs;
    logic [9:0]             bk;
    logic                   ph;
    logic [2:0]             sel;
    logic                   led;
    logic                   ack;
    logic [31:0]            rd;
    logic                   err;
  } rfs_st_t;
  rfs_st_t s_reg;
  rfs_st_t s_next;
  // refuse tick settings the timers cannot serve
  if (TICK_CYC < 2 || VSTEP_TK < 1) begin : g_bad_tick
    $error("rfs_top: tick period out of range");
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  // is a byte address inside the writable config block
  function automatic logic is_cfg(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a < A_STAT);
  endfunction
  // half period in ticks for a blink pattern
  function automatic logic [9:0] half_of(input logic [2:0] sel);
    unique case (sel)
      LED_CB1: return 10'(CB1_HALF_TK);
      LED_CB2: return 10'(CB2_HALF_TK);
      default: return 10'(OT_HALF_TK);
    endcase
  endfunction

  // ****************************************************************
  // qualification timers: 0..3 under, 4..7 over, 8..9 circuit break
  // ****************************************************************
  rfs_qual_if #(.DW(DW)) q [NQ] ();
  logic [NQ-1:0] fired;
  logic [NQ-1:0] running;
  logic          tick;
  logic [16:0]   ipos;
  logic [16:0]   ineg;
  logic          awake_mon;
  assign tick      = (s_reg.tdiv == 32'(TICK_CYC - 1));
  assign ipos      = current_i[15] ? 17'h0_0000 : {1'b0, current_i};
  assign ineg      = current_i[15] ? 17'h0_0000 - {current_i[15], current_i} : 17'h0_0000;
  assign awake_mon = (s_reg.st != ST_LOWPWR);
  generate
    for (genvar i = 0; i < NQ; i++) begin : g_q
      logic [31:0] r;
      assign r         = s_reg.cfg[(i < 8) ? (A_UV0 / 4 + i) : (A_CB0 / 4 + i - 8)];
      assign q[i].tick = tick;
      if (i < 8) begin : g_v
        // voltage pair: threshold in 0.1 V units, delay in 2 ms units
        assign q[i].dly  = DW'(r[F_VDL +: VDL_W]) * DW'(VSTEP_TK);
        assign q[i].cond = awake_mon && r[F_EN] &&
          ((i < 4) ? (volt_i < r[F_VTH +: VTH_W])
                   : (volt_i > r[F_VTH +: VTH_W]));
      end else begin : g_c
        // circuit break: level compared on the programmed direction
        logic rev;
        assign rev       = BIDIR && r[F_DIR];
        assign q[i].dly  = DW'(r[F_CDL +: CDL_W]) * DW'(VSTEP_TK);
        assign q[i].cond = awake_mon && s_reg.closed && r[F_EN] &&
          ((rev ? ineg : ipos) > {1'b0, r[F_CLV +: 16]});
      end
      assign fired[i]   = q[i].fired;
      assign running[i] = q[i].running;
      rfs_qual_tmr #(.DW(DW)) u_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .qi        (q[i])
      );
    end
  endgenerate
  // ****************************************************************
  // derived conditions
  // ****************************************************************
  logic        vfault;
  logic        hi_fault;
  logic        idle;
  logic        uv_ok;
  logic        m_chg;
  logic        o_chg;
  logic [31:0] ctrl;
  logic [1:0]  pol;
  logic        wr;

  assign ctrl     = s_reg.cfg[A_CTRL / 4];
  assign pol      = ctrl[F_POL +: 2];
  assign vfault   = |fired[7:0];
  assign hi_fault = (s_reg.cb != 2'h0) || oc_fault_i || ot_fault_i;
  assign m_chg    = s_reg.m2 ^ s_reg.mp;
  assign o_chg    = s_reg.o2 ^ s_reg.op;
  // idle: no timers, no current or heat fault, low current when closed
  assign idle = !(|running) && !hi_fault && (s_reg.lock == 14'h0) &&
    (!s_reg.closed || ipos < {1'b0, s_reg.cfg[A_SLPI / 4][15:0]});
  always_comb begin
    uv_ok = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (s_reg.cfg[A_UV0 / 4 + k][F_EN] &&
          volt_i > s_reg.cfg[A_UV0 / 4 + k][F_VTH +: VTH_W]) begin
        uv_ok = 1'b1;
      end
    end
  end
  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next      = s_reg;
    s_next.tdiv = tick ? 32'h0000_0000 : s_reg.tdiv + 32'h0000_0001;
    // trigger synchronisers and previous samples
    s_next.m1 = main_trig_i;
    s_next.o1 = ovr_trig_i;
    s_next.m2 = s_reg.m1;
    s_next.o2 = s_reg.o1;
    s_next.mp = s_reg.m2;
    s_next.op = s_reg.o2;

    // apb: one setup cycle registers read data, access completes at once
    s_next.ack = psel_i && !penable_i;
    if (psel_i && !penable_i) begin
      s_next.err = !is_cfg(paddr_i) && (paddr_i != A_STAT);
      s_next.rd  = 32'h0000_0000;
      if (is_cfg(paddr_i)) begin
        s_next.rd = s_reg.cfg[paddr_i[7:2]];
      end else if (paddr_i == A_STAT) begin
        s_next.rd = {16'h0000, s_reg.tries, s_reg.lock != 14'h0, s_reg.st,
                     oc_fault_i, ot_fault_i, vfault, s_reg.cb, s_reg.led,
                     low_power_o, s_reg.closed};
      end
    end
    if (wr && is_cfg(paddr_i)) begin
      s_next.cfg[paddr_i[7:2]] = pwdata_i;
    end

    // lockout countdown
    if (tick && s_reg.lock != 14'h0) begin
      s_next.lock = s_reg.lock - 14'h0001;
    end
    // circuit-break reset once lockout has run out
    if (s_reg.cb != 2'h0 && s_reg.lock == 14'h0) begin
      if (pol == POL_UNLIM) begin
        s_next.cb = 2'h0;
      end else if (pol == POL_LIMIT && s_reg.tries < ctrl[F_TRY +: 4]) begin
        s_next.cb    = 2'h0;
        s_next.tries = s_reg.tries + 4'h1;
      end else if (s_reg.m2 && !s_reg.mp) begin
        s_next.cb    = 2'h0;
        s_next.tries = 4'h0;
      end
    end
    // a new trip wins over any reset in the same cycle
    if (fired[9:8] != 2'h0) begin
      s_next.cb   = s_next.cb | fired[9:8];
      s_next.lock = 14'(LOCK_TK);
    end

    // sleep manager
    unique case (s_reg.st)
      ST_AWAKE: begin
        if (!ctrl[F_SLEEP] || !idle) begin
          s_next.slp = 32'h0000_0000;
        end else if (s_reg.slp >= s_reg.cfg[A_SLPT / 4]) begin
          s_next.st  = ST_LOWPWR;
          s_next.wd  = 16'h0000;
          s_next.uvs = vfault;
        end else if (tick) begin
          s_next.slp = s_reg.slp + 32'h0000_0001;
        end
      end
      ST_LOWPWR: begin
        if (tick) begin
          s_next.wd = s_reg.wd + 16'h0001;
        end
        if (tick && s_reg.wd == 16'(WD_TK - 1) && ctrl[F_WK_WDT]) begin
          s_next.st = ST_PROBE;
          s_next.pr = 7'h00;
        end
      end
      ST_PROBE: begin
        if (tick) begin
          s_next.pr = s_reg.pr + 7'h01;
        end
        if (!idle || (s_reg.uvs && uv_ok)) begin
          s_next.st  = ST_AWAKE;
          s_next.slp = 32'h0000_0000;
        end else if (s_reg.pr == 7'(PROBE_TK)) begin
          s_next.st = ST_LOWPWR;
          s_next.wd = 16'h0000;
        end
      end
    endcase
    if (s_reg.st != ST_AWAKE &&
        ((m_chg && ctrl[F_WK_MN]) || (o_chg && ctrl[F_WK_OV]))) begin
      s_next.st  = ST_AWAKE;
      s_next.slp = 32'h0000_0000;
    end

    // switch array: main trigger, overridden voltage fault, hard faults
    s_next.closed = s_reg.m2 && !hi_fault && s_reg.st != ST_LOWPWR &&
                    (!vfault || s_reg.o2);

    // fault led source by priority
    if (oc_fault_i) begin
      s_next.sel = LED_OC;
    end else if (s_reg.cb[1]) begin
      s_next.sel = LED_CB2;
    end else if (s_reg.cb[0]) begin
      s_next.sel = LED_CB1;
    end else if (ot_fault_i) begin
      s_next.sel = LED_OT;
    end else if (vfault) begin
      s_next.sel = LED_VOLT;
    end else begin
      s_next.sel = LED_NONE;
    end
    // blink phase restarts when the shown fault changes
    if (s_next.sel != s_reg.sel) begin
      s_next.bk = 10'h000;
      s_next.ph = 1'b1;
    end else if (tick) begin
      if (s_reg.bk == half_of(s_reg.sel) - 10'h001) begin
        s_next.bk = 10'h000;
        s_next.ph = !s_reg.ph;
      end else begin
        s_next.bk = s_reg.bk + 10'h001;
      end
    end
    unique case (s_reg.sel)
      LED_NONE:         s_next.led = 1'b0;
      LED_VOLT:         s_next.led = 1'b1;
      LED_OC:           s_next.led = oc_led_i;
      default:          s_next.led = s_reg.ph;
    endcase
    if (s_reg.st == ST_LOWPWR) begin
      s_next.led = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_reg     <= '0;
      s_reg.cfg <= {NREG{CFG_RST}};
      s_reg.st  <= ST_AWAKE;
      s_reg.ph  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign prdata_o       = s_reg.rd;
  assign pready_o       = s_reg.ack && psel_i && penable_i;
  assign pslverr_o      = pready_o && s_reg.err;
  assign switch_close_o = s_reg.closed;
  assign fault_led_o    = s_reg.led;
  assign low_power_o    = (s_reg.st == ST_LOWPWR);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb_clk @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_lock_open: assert property ((s_reg.lock != 14'h0) |-> ##1 !switch_close_o)
    else $error("array closed during lockout");
  a_cb_trip: assert property ((fired[9:8] != 2'h0) |=> (s_reg.cb != 2'h0) &&
    s_reg.lock == 14'(LOCK_TK))
    else $error("trip did not latch with full lockout");
  a_volt_open: assert property (vfault && !s_reg.o2 |=> !switch_close_o)
    else $error("voltage fault left the array closed");
  a_ovr_close: assert property (vfault && s_reg.o2 && s_reg.m2 && !hi_fault &&
    s_reg.st != ST_LOWPWR |=> switch_close_o)
    else $error("override with main did not close the array");
  a_sleep_dark: assert property (low_power_o |=> !fault_led_o && !switch_close_o)
    else $error("indicators or array active in low power");
  a_slp_clear: assert property (s_reg.st == ST_AWAKE && !idle |=> s_reg.slp == 32'h0)
    else $error("sleep timer not cleared on leaving idle");
  a_probe_len: assert property (s_reg.st == ST_PROBE |-> s_reg.pr <= 7'(PROBE_TK))
    else $error("probe window overran");
  a_trig_wake: assert property (s_reg.st != ST_AWAKE && m_chg && ctrl[F_WK_MN]
    |=> s_reg.st == ST_AWAKE)
    else $error("main trigger change did not wake");
  a_led_prio: assert property (oc_fault_i |=> s_reg.sel == LED_OC)
    else $error("led did not follow highest fault");
  a_tick_gap: assert property (tick |=> !tick)
    else $error("tick wider than one cycle");
  a_apb_err: assert property (pready_o && !is_cfg(paddr_i) && paddr_i != A_STAT
    |-> pslverr_o)
    else $error("unmapped access not flagged");
  c_cb_trip:   cover property ((fired[9:8] != 2'h0) ##1 s_reg.cb != 2'h0);
  c_low_power: cover property (s_reg.st == ST_AWAKE ##1 s_reg.st == ST_LOWPWR);
  c_probe:     cover property (s_reg.st == ST_PROBE ##1 s_reg.st == ST_LOWPWR);
  c_override:  cover property (vfault && switch_close_o);
endmodule
